//--- src/wdt_protect.sv
// Watchdog protection logic: write guards, deferred internal reset
`default_nettype none
// Behaviour
// R1: A second mode register write after reset raises the internal reset.
// R2: A violation while the source clock stands waits until it runs again.
// R3: Software writes the mode register as a whole byte only.
// R4: Once halted by software, the watchdog stays halted and a further mode write raises no reset.
// R5: Any single-bit access to the clear register raises the internal reset.
// R6: The clear register always reads 9A, unlike the AC clear key.
// R7: With the fixed option the counter runs always, stop mode included.
// R8: Software clears the watchdog during stop from an oscillator timer interrupt.
// R9: An overflow, stop mode included, raises the internal reset.
// R10: The mode register takes exactly one byte write after reset.
// R11: Stoppable option pauses in halt and stop, then resumes from held count.
// R12: Internal reset is one pulse restoring both registers and re-arming mode.
module wdt_protect (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       stoppable_opt,
    input  wire logic       src_clk_run,
    input  wire logic       halt_mode,
    input  wire logic       stop_mode,
    input  wire logic       mode_wr_en,
    input  wire logic       mode_wr_bit,
    input  wire logic [7:0] mode_wr_data,
    output logic      [7:0] mode_rd_data,
    input  wire logic       clear_wr_en,
    input  wire logic       clear_wr_bit,
    input  wire logic [7:0] clear_wr_data,
    output logic      [7:0] clear_rd_data,
    output logic            wdt_halt_bit,
    output logic            internal_reset
);
    wdt_pkg::prot_state_t st;
    wdt_pkg::prot_state_t st_next;
    wdt_count_if          cif ();

    logic mode_byte_wr;
    logic viol_mode;
    logic viol_clear;
    logic any_viol;
    logic power_pause;

    wdt_counter u_counter (
        .clk   (clk),
        .reset (reset),
        .cif   (cif)
    );

    // ----------------------------------------------------------------
    // Violation detection
    // ----------------------------------------------------------------
    always_comb begin
        // R3 single-bit mode writes
        // Bit writes to the mode register are ignored, not stored
        mode_byte_wr = mode_wr_en && !mode_wr_bit;
        // R1 second write check
        // R4 halted suppresses reset
        viol_mode    = mode_byte_wr && st.mode_written && !st.halted;
        // R5 bit access trap
        viol_clear   = clear_wr_en && clear_wr_bit;
        // R9 overflow trap
        any_viol     = viol_mode || viol_clear || cif.overflow;
    end

    // ----------------------------------------------------------------
    // Counter control
    // ----------------------------------------------------------------
    always_comb begin
        // R11 pause in halt/stop
        power_pause = stoppable_opt && (halt_mode || stop_mode);
        // R7 fixed option runs always
        cif.run     = st.src_run && !st.halted && !power_pause && !st.rst_pulse;
        cif.clear   = st.rst_pulse
                   || (clear_wr_en && !clear_wr_bit && (clear_wr_data == wdt_pkg::CLEAR_KEY));
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st;
        // Three-stage synchroniser; only stages two and three are compared
        st_next.sync = {st.sync[1:0], src_clk_run};
        if (st.sync[1] == st.sync[2]) begin
            st_next.src_run = st.sync[2];
        end
        if (st.rst_pulse) begin
            // R12 restore and re-arm
            st_next.mode_val     = wdt_pkg::MODE_INIT;
            st_next.mode_written = 1'b0;
            st_next.halted       = 1'b0;
            st_next.pending      = 1'b0;
            st_next.rst_pulse    = 1'b0;
        end else begin
            // R10 one byte write
            if (mode_byte_wr && !st.mode_written) begin
                st_next.mode_val     = mode_wr_data;
                st_next.mode_written = 1'b1;
                // R4 sticky software halt
                if (stoppable_opt && mode_wr_data[wdt_pkg::HALT_BIT_POS]) begin
                    st_next.halted = 1'b1;
                end
            end
            // R2 defer until clock runs
            if ((any_viol || st.pending) && st.src_run) begin
                st_next.rst_pulse = 1'b1;
                st_next.pending   = 1'b0;
            end else if (any_viol) begin
                st_next.pending   = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st.sync         <= wdt_pkg::SYNC_INIT;
            st.src_run      <= 1'b0;
            st.mode_val     <= wdt_pkg::MODE_INIT;
            st.mode_written <= 1'b0;
            st.halted       <= 1'b0;
            st.pending      <= 1'b0;
            st.rst_pulse    <= 1'b0;
        end else begin
            st <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign mode_rd_data   = st.mode_val;
    // R6 fixed read value
    assign clear_rd_data  = wdt_pkg::CLEAR_READ_VAL;
    assign wdt_halt_bit   = st.mode_val[wdt_pkg::HALT_BIT_POS];
    assign internal_reset = st.rst_pulse;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_second_write;
        @(posedge clk) disable iff (reset)
        (mode_byte_wr && st.mode_written && !st.halted && st.src_run && !st.rst_pulse)
            |=> internal_reset;
    endproperty
    a_second_write: assert property (p_second_write) // R1
        else $error("Second mode write gave no internal reset");

    sequence s_deferred;
        st.pending && !st.src_run;
    endsequence
    sequence s_resume;
        st.pending && st.src_run && !st.rst_pulse;
    endsequence

    property p_defer_hold;
        @(posedge clk) disable iff (reset)
        s_deferred |=> (st.pending && !internal_reset);
    endproperty
    a_defer_hold: assert property (p_defer_hold) // R2
        else $error("Deferred reset lost or fired while clock stood");

    property p_defer_fire;
        @(posedge clk) disable iff (reset)
        s_resume |=> internal_reset;
    endproperty
    a_defer_fire: assert property (p_defer_fire) // R2
        else $error("Deferred reset did not fire on clock resume");

    property p_halt_quiet;
        @(posedge clk) disable iff (reset)
        (st.halted && !st.pending && !st.rst_pulse && !clear_wr_en)
            |=> (!internal_reset && st.halted && !cif.run);
    endproperty
    a_halt_quiet: assert property (p_halt_quiet) // R4
        else $error("Halted watchdog restarted or reset");

    property p_bit_clear;
        @(posedge clk) disable iff (reset)
        (clear_wr_en && clear_wr_bit && st.src_run && !st.rst_pulse) |=> internal_reset;
    endproperty
    a_bit_clear: assert property (p_bit_clear) // R5
        else $error("Bit access to clear register gave no reset");

    property p_read_val;
        @(posedge clk) disable iff (reset)
        clear_rd_data == wdt_pkg::CLEAR_READ_VAL;
    endproperty
    a_read_val: assert property (p_read_val) // R6
        else $error("Clear register read value wrong");

    property p_nonstop_run;
        @(posedge clk) disable iff (reset)
        (!stoppable_opt && st.src_run && !st.rst_pulse) |-> cif.run;
    endproperty
    a_nonstop_run: assert property (p_nonstop_run) // R7
        else $error("Fixed option counter not running");

    property p_overflow;
        @(posedge clk) disable iff (reset)
        (cif.overflow && st.src_run && !st.rst_pulse) |=> internal_reset;
    endproperty
    a_overflow: assert property (p_overflow) // R9
        else $error("Overflow gave no internal reset");

    property p_first_write;
        @(posedge clk) disable iff (reset)
        (mode_byte_wr && !st.mode_written && !st.rst_pulse)
            |=> (st.mode_written && mode_rd_data == $past(mode_wr_data));
    endproperty
    a_first_write: assert property (p_first_write) // R10
        else $error("First mode write not stored");

    property p_pulse;
        @(posedge clk) disable iff (reset)
        internal_reset |=> (!internal_reset && !st.mode_written
                            && mode_rd_data == wdt_pkg::MODE_INIT && cif.count == 16'h0000);
    endproperty
    a_pulse: assert property (p_pulse) // R12
        else $error("Internal reset not a single restoring pulse");
endmodule
`default_nettype wire

//--- shared/wdt_pkg.sv
// Constants and state types shared by the watchdog protection logic
`default_nettype none
package wdt_pkg;
    // ----------------------------------------------------------------
    // Register values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0]  CLEAR_KEY      = 8'hAC;
    localparam logic [7:0]  CLEAR_READ_VAL = 8'h9A;
    localparam logic [7:0]  MODE_INIT      = 8'h67;
    localparam int unsigned HALT_BIT_POS   = 4;
    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    localparam int unsigned CNT_W          = 16;
    localparam logic [15:0] CNT_INIT       = 16'h0000;
    localparam logic [15:0] CNT_OVF        = 16'h0FFF;
    localparam int unsigned SYNC_LEN       = 3;
    localparam logic [2:0]  SYNC_INIT      = 3'h0;

    typedef struct packed {
        logic [SYNC_LEN-1:0] sync;
        logic                src_run;
        logic [7:0]          mode_val;
        logic                mode_written;
        logic                halted;
        logic                pending;
        logic                rst_pulse;
    } prot_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } cnt_state_t;
endpackage
`default_nettype wire

//--- shared/wdt_count_if.sv
// Carrier between the protection logic and its counter
`default_nettype none
interface wdt_count_if;
    logic        run;
    logic        clear;
    logic        overflow;
    logic [15:0] count;

    modport ctrl (
        output run,
        output clear,
        input  overflow,
        input  count
    );
    modport cnt (
        input  run,
        input  clear,
        output overflow,
        output count
    );
endinterface
`default_nettype wire

//--- src/wdt_counter.sv
// Watchdog up-counter with overflow detection
`default_nettype none
module wdt_counter (
    input  wire logic   clk,
    input  wire logic   reset,
    wdt_count_if.cnt    cif
);
    wdt_pkg::cnt_state_t st;
    wdt_pkg::cnt_state_t st_next;

    // ----------------------------------------------------------------
    // Count
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st;
        if (cif.clear) begin
            st_next.count = wdt_pkg::CNT_INIT;
        end else if (cif.run) begin
            if (st.count == wdt_pkg::CNT_OVF) begin
                st_next.count = wdt_pkg::CNT_INIT;
            end else begin
                st_next.count = st.count + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st.count <= wdt_pkg::CNT_INIT;
        end else begin
            st <= st_next;
        end
    end

    assign cif.overflow = cif.run && (st.count == wdt_pkg::CNT_OVF);
    assign cif.count    = st.count;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_step;
        cif.run && !cif.clear && (st.count != wdt_pkg::CNT_OVF);
    endsequence

    property p_count_step;
        @(posedge clk) disable iff (reset)
        s_step |=> (st.count == $past(st.count) + 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step) // R7
        else $error("Counter did not advance while running");

    property p_count_hold;
        @(posedge clk) disable iff (reset)
        (!cif.run && !cif.clear) |=> (st.count == $past(st.count));
    endproperty
    a_count_hold: assert property (p_count_hold) // R11
        else $error("Counter moved while paused");
endmodule
`default_nettype wire

//--- sim/watchdog_protection_logic_test.sv
// Self-checking testbench for the watchdog protection logic
`default_nettype none
module watchdog_protection_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic       clk, reset, stoppable_opt, src_clk_run, halt_mode, stop_mode;
    logic       mode_wr_en, mode_wr_bit, clear_wr_en, clear_wr_bit;
    logic [7:0] mode_wr_data, clear_wr_data, mode_rd_data, clear_rd_data, d;
    logic       wdt_halt_bit, internal_reset, prev_hi;
    int         cyc, num_errors, total_checks;
    typedef struct {int lo; int hi;} note_t;
    note_t      notes[$];
    note_t      n;

    wdt_protect DUT (.clk(clk), .reset(reset), .stoppable_opt(stoppable_opt),
        .src_clk_run(src_clk_run), .halt_mode(halt_mode), .stop_mode(stop_mode),
        .mode_wr_en(mode_wr_en), .mode_wr_bit(mode_wr_bit), .mode_wr_data(mode_wr_data),
        .mode_rd_data(mode_rd_data), .clear_wr_en(clear_wr_en),
        .clear_wr_bit(clear_wr_bit), .clear_wr_data(clear_wr_data),
        .clear_rd_data(clear_rd_data), .wdt_halt_bit(wdt_halt_bit),
        .internal_reset(internal_reset));

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic do_reset(input logic opt);
        @(posedge clk);
        reset <= 1;
        stoppable_opt <= opt;
        repeat (10) @(posedge clk);
        reset <= 0;
        // Let the source-clock synchroniser settle before any violation
        repeat (5) @(posedge clk);
    endtask

    // One register write; lo below zero means no internal reset is expected
    task automatic put(input logic sel, input logic bacc, input logic [7:0] v,
                       input int lo, input int hi);
        @(posedge clk);
        if (lo >= 0) notes.push_back('{cyc + lo, cyc + hi});
        if (sel) begin
            mode_wr_en <= 1;
            mode_wr_bit <= bacc;
            mode_wr_data <= v;
        end else begin
            clear_wr_en <= 1;
            clear_wr_bit <= bacc;
            clear_wr_data <= v;
        end
        @(posedge clk);
        mode_wr_en <= 0;
        clear_wr_en <= 0;
    endtask

    task automatic chk_regs(input logic [7:0] m, input logic h, input int waits);
        repeat (waits) @(negedge clk);
        check("mode_rd_data", mode_rd_data, m);
        check("wdt_halt_bit", wdt_halt_bit, h);
        check("clear_rd_data", clear_rd_data, 8'h9A);
    endtask
    // ----------------------------------------------------------------
    // Reset pulse monitor
    // ----------------------------------------------------------------
    always @(negedge clk) begin
        if (!reset && internal_reset === 1'b1) begin
            if (prev_hi) check("reset_width", 1, 0);
            else if (notes.size() == 0) check("reset_cause", 1, 0);
            else begin
                n = notes.pop_front();
                check("reset_time", cyc >= n.lo && cyc <= n.hi, 1);
            end
        end else if (!reset) begin
            check("reset_idle", internal_reset, 1'b0);
        end
        prev_hi = internal_reset;
    end

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        {reset, stoppable_opt, halt_mode, stop_mode, mode_wr_en, mode_wr_bit} = 6'h20;
        {clear_wr_en, clear_wr_bit, mode_wr_data, clear_wr_data, prev_hi} = '0;
        src_clk_run = 1;
        cyc = 0;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(33));
        do_reset(0);
        chk_regs(8'h67, 0, 1);
        // one write, bit writes ignored, second write resets
        for (int i = 0; i < 3; i++) begin
            put(1, 1, 8'($urandom), -1, -1);
            chk_regs(8'h67, 0, 1);
            d = {3'b011, 5'($urandom)};
            put(1, 0, d, -1, -1);
            chk_regs(d, d[4], 1);
            put(1, 0, 8'($urandom), 2, 2);
            chk_regs(8'h67, 0, 2);
        end
        // bit access to the clear register
        for (int i = 0; i < 4; i++) begin
            put(0, 1, 8'($urandom), 2, 2);
            chk_regs(8'h67, 0, 2);
        end
        // counter runs in stop mode, only the key clears it
        @(posedge clk);
        stop_mode <= 1;
        repeat (500) @(posedge clk);
        put(0, 0, 8'hAC, 4094, 4102);
        repeat (3000) @(posedge clk);
        put(0, 0, 8'($urandom_range(0, 171)), -1, -1);
        repeat (1200) @(posedge clk);
        stop_mode <= 0;
        // pause in halt then stop, resume from the held count
        do_reset(1);
        put(0, 0, 8'hAC, 9094, 9102);
        repeat (2000) @(posedge clk);
        halt_mode <= 1;
        repeat (3000) @(posedge clk);
        halt_mode <= 0;
        stop_mode <= 1;
        repeat (2000) @(posedge clk);
        stop_mode <= 0;
        repeat (2200) @(posedge clk);
        // halted watchdog stays halted and a rewrite gives no reset
        d = 8'($urandom) | 8'h10;
        put(1, 0, d, -1, -1);
        chk_regs(d, 1, 1);
        put(1, 0, 8'($urandom) & 8'hEF, -1, -1);
        chk_regs(d, 1, 1);
        repeat (5000) @(posedge clk);
        chk_regs(d, 1, 1);
        put(0, 1, 8'($urandom), 2, 2);
        chk_regs(8'h67, 0, 2);
        // violation with the source clock stopped waits for it
        @(posedge clk);
        src_clk_run <= 0;
        repeat (6) @(posedge clk);
        put(1, 0, 8'h60, -1, -1);
        put(1, 0, 8'h61, -1, -1);
        repeat (20) @(posedge clk);
        notes.push_back('{cyc + 2, cyc + 10});
        src_clk_run <= 1;
        repeat (20) @(posedge clk);
        check("missing_resets", notes.size(), 0);
        complete_run();
    end
endmodule
`default_nettype wire
